// file: rtl/sync_serial_port_defs.svh
`ifndef SYNC_SERIAL_PORT_DEFS_SVH
`define SYNC_SERIAL_PORT_DEFS_SVH

// register byte addresses
`define ADDR_STATUS 8'h94
`define ADDR_CONFIG 8'hA0
`define ADDR_IRQ_STATUS 8'hA4
`define ADDR_IRQ_MASK 8'hA8
`define ADDR_DATA 8'hAC

// status field positions
`define ST_SAMPLE 7
`define ST_EDGE 6
`define ST_DATA_ADDR 5
`define ST_STOP 4
`define ST_START 3
`define ST_DIR 2
`define ST_ADDR_UPD 1
`define ST_FULL 0

// config field positions
`define CF_ENABLE 0
`define CF_I2C 1
`define CF_MASTER 2
`define CF_POLARITY 3
`define CF_TEN_BIT 4

// interrupt bit positions
`define IRQ_RX 0
`define IRQ_START 1
`define IRQ_STOP 2
`define IRQ_ADDR_UPD 3

`define IRQ_TOP 3
`define SYNC_IDLE 2'h3
`define LINE_IDLE 1'b1

`define RESET_BYTE 8'h00
`define SOFT_BITS_MASK 8'hC0
`define BITS_PER_BYTE 4'h8

`endif

// file: rtl/sync_serial_port_pkg.sv
package sync_serial_port_pkg;
    // one completed byte event from the shift engine
    typedef struct packed {
        logic valid;
        logic is_data;
        logic [7:0] value;
    } byte_event_s;

    // config bundle steering the pins
    typedef struct packed {
        logic enable;
        logic i2c;
        logic master;
        logic polarity;
        logic ten_bit;
    } port_cfg_s;
endpackage

// file: rtl/sync_serial_port_status.sv
`timescale 1ns/1ns
`default_nettype none
`include "sync_serial_port_defs.svh"

module sync_serial_port_status (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // register port
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    output logic irq_o,
    // link pins, from outside the clock domain
    input wire logic scl_i,
    input wire logic sda_i,
    // events from the shift engine, same clock
    input wire logic rx_done_i,
    input wire logic rx_is_data_i,
    input wire logic [7:0] rx_byte_i,
    input wire logic tx_start_i,
    input wire logic tx_bits_done_i,
    input wire logic addr_match_i,
    input wire logic addr_rw_i,
    input wire logic nack_i,
    input wire logic addr_high_done_i,
    input wire logic [4:0] master_req_i,
    // outputs steering the pin and shift logic
    output logic sample_at_end_o,
    output logic slew_ctrl_on_o,
    output logic shift_on_rise_o,
    output logic smbus_levels_o,
    output logic clk_idle_level_o,
    output logic pins_to_port_o,
    output logic i2c_mode_o,
    output logic master_idle_o
);

    // synchronisers for the link pins
    // both pins idle high on the bus, so the chains reset to one and
    // no false start or stop can follow the release of reset
    logic [1:0] scl_sync_q;
    logic [1:0] sda_sync_q;
    logic scl_last_q;
    logic sda_last_q;
    // register state
    // every flag below is one bit of the status byte or its
    // companion config and interrupt registers
    logic [1:0] soft_bits_q; // sample phase and edge select
    sync_serial_port_pkg::port_cfg_s cfg_q;
    logic data_addr_q;
    logic stop_q;
    logic start_q;
    logic dir_q;
    logic addr_upd_q;
    logic full_q;
    logic [7:0] buf_q;
    logic [3:0] irq_stat_q;
    logic [3:0] irq_mask_q;
    // decoded conditions
    // these are plain wires, never registered, so they act in the
    // same cycle as the event that causes them
    logic start_det;
    logic stop_det;
    logic rd_buf;
    logic [3:0] irq_set;
    sync_serial_port_pkg::byte_event_s rx_ev;

    // address decode, used by the write logic and the data-read strobe
    // kept as a function so every register compares the address the same
    // way; a full byte compare means no aliasing on the port
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_a);
        hit = (a == ref_a);
    endfunction

    assign rx_ev = '{valid: rx_done_i, is_data: rx_is_data_i, value: rx_byte_i};
    assign rd_buf = rd_i && hit(addr_i, `ADDR_DATA);

    // two flops per pin; only the second is read by the edge logic
    // the link clock is sampled by the system clock, so the link must run
    // well below a quarter of it for the edge logic to see every level
    // the last-value flops give the edge detectors their previous sample
    // trade-off: two cycles of latency for a clean, metastable-free level
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            scl_sync_q <= `SYNC_IDLE;
            sda_sync_q <= `SYNC_IDLE;
            scl_last_q <= `LINE_IDLE;
            sda_last_q <= `LINE_IDLE;
        end else begin
            scl_sync_q <= {scl_sync_q[0], scl_i};
            sda_sync_q <= {sda_sync_q[0], sda_i};
            scl_last_q <= scl_sync_q[1];
            sda_last_q <= sda_sync_q[1];
        end
    end

    // start: sda falls while scl high; stop: sda rises while scl high
    // the clock must be high on both samples, so a data change right at
    // a clock edge is not mistaken for a bus condition
    // only decoded in two-wire mode; the serial-peripheral mode has no
    // such conditions and its data line may toggle freely
    assign start_det = cfg_q.i2c && scl_sync_q[1] && scl_last_q
                       && sda_last_q && !sda_sync_q[1];
    assign stop_det = cfg_q.i2c && scl_sync_q[1] && scl_last_q
                      && !sda_last_q && sda_sync_q[1];

    // configuration register, mode is one of two protocols
    // a single mode bit makes the two protocols mutually exclusive by
    // construction: there is no encoding that selects both at once
    // software should clear enable before changing mode, since the
    // shift engine is not reset here
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            cfg_q <= '0;
        end else if (wr_i && hit(addr_i, `ADDR_CONFIG)) begin
            cfg_q.enable <= wdata_i[`CF_ENABLE];
            cfg_q.i2c <= wdata_i[`CF_I2C];
            cfg_q.master <= wdata_i[`CF_MASTER];
            cfg_q.polarity <= wdata_i[`CF_POLARITY];
            cfg_q.ten_bit <= wdata_i[`CF_TEN_BIT];
        end
    end

    // only the two upper status bits take software writes
    // the six lower bits are hardware flags; a status write never
    // disturbs them, so software can change the phase bits at any time
    // their meaning depends on the mode bit of the config register
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            soft_bits_q <= 2'h0;
        end else if (wr_i && hit(addr_i, `ADDR_STATUS)) begin
            soft_bits_q <= wdata_i[`ST_SAMPLE:`ST_EDGE];
        end
    end

    // data/address kind of the last byte moved
    // a received byte reports its own kind; a transmitted byte is data,
    // since addresses are sent by the engine before any data starts
    // outside two-wire mode the flag simply holds its last value
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            data_addr_q <= 1'b0;
        end else if (cfg_q.i2c && rx_ev.valid) begin
            data_addr_q <= rx_ev.is_data;
        end else if (cfg_q.i2c && tx_start_i) begin
            data_addr_q <= 1'b1;
        end
    end

    // start and stop flags: the last condition seen wins
    // setting one always clears the other, so at most one reads high
    // clearing the enable wins over a condition in the same cycle,
    // because a disabled port must not report bus activity
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || !cfg_q.enable) begin
            start_q <= 1'b0;
            stop_q <= 1'b0;
        end else if (start_det) begin
            start_q <= 1'b1;
            stop_q <= 1'b0;
        end else if (stop_det) begin
            stop_q <= 1'b1;
            start_q <= 1'b0;
        end
    end

    // direction flag has two meanings by master/slave role
    // master: high while a transmission runs
    // slave: the read/write bit of the last matched address
    // limitation: in the slave role the value is only meaningful up to
    // the next start, stop or not-acknowledge, after which it reads zero
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            dir_q <= 1'b0;
        end else if (cfg_q.master) begin
            if (tx_start_i) begin
                dir_q <= 1'b1;
            end else if (tx_bits_done_i) begin
                dir_q <= 1'b0;
            end
        end else if (addr_match_i) begin
            dir_q <= addr_rw_i;
        end else if (start_det || stop_det || nack_i) begin
            dir_q <= 1'b0;
        end
    end

    // ten-bit address update request; cleared by a write to the data register
    // the hardware event wins over the clearing write, so a request that
    // lands in the same cycle as the write is not lost
    // only raised with ten-bit addressing selected in two-wire mode
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            addr_upd_q <= 1'b0;
        end else if (cfg_q.i2c && cfg_q.ten_bit && addr_high_done_i) begin
            addr_upd_q <= 1'b1;
        end else if (wr_i && hit(addr_i, `ADDR_DATA)) begin
            addr_upd_q <= 1'b0;
        end
    end

    // buffer full: set wins over the clearing read in the same cycle
    // a received byte marks the buffer full in either protocol
    // on two-wire transmit it stands for the data bits only; the engine
    // signals the end of them before the acknowledge slot
    // hazard: a read racing a new byte leaves the flag set, which is safe
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            full_q <= 1'b0;
        end else if (rx_ev.valid) begin
            full_q <= 1'b1;
        end else if (cfg_q.i2c && tx_start_i) begin
            full_q <= 1'b1;
        end else if (cfg_q.i2c && tx_bits_done_i) begin
            full_q <= 1'b0;
        end else if (rd_buf) begin
            full_q <= 1'b0;
        end
    end

    // received byte holding; software writes load the outgoing byte
    // one shared byte for both directions, as the port is half duplex
    // from the software's view; a received byte overwrites a pending
    // outgoing one, so software must not write while receiving
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            buf_q <= `RESET_BYTE;
        end else if (rx_ev.valid) begin
            buf_q <= rx_ev.value;
        end else if (wr_i && hit(addr_i, `ADDR_DATA)) begin
            buf_q <= wdata_i;
        end
    end

    // sticky interrupt bits: set wins over write-one-to-clear
    // writing a one clears only that bit; zeros leave bits untouched,
    // so software can acknowledge one event without losing another
    // an event in the clearing cycle stays pending
    assign irq_set = {addr_high_done_i && cfg_q.ten_bit, stop_det, start_det, rx_ev.valid};
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            irq_stat_q <= 4'h0;
        end else if (wr_i && hit(addr_i, `ADDR_IRQ_STATUS)) begin
            irq_stat_q <= (irq_stat_q & ~wdata_i[`IRQ_TOP:0]) | irq_set;
        end else begin
            irq_stat_q <= irq_stat_q | irq_set;
        end
    end

    // interrupt mask
    // same layout as the status bits; a one lets that event through
    // all events are masked after reset
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            irq_mask_q <= 4'h0;
        end else if (wr_i && hit(addr_i, `ADDR_IRQ_MASK)) begin
            irq_mask_q <= wdata_i[`IRQ_TOP:0];
        end
    end

    // interrupt line, registered
    // registering costs one cycle of latency but keeps the pin glitch free
    // the line is a level: it stays high until software clears the cause
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(irq_stat_q & irq_mask_q);
        end
    end

    // read data, valid the cycle after the strobe; unmapped reads zero
    // returning zero outside read cycles keeps the shared read bus quiet
    // and lets an or-tree combine several slaves without a mux
    // reads have no side effect here except the buffer-full clear
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rdata_o <= `RESET_BYTE;
        end else if (rd_i) begin
            case (addr_i)
                `ADDR_STATUS: begin
                    rdata_o <= {soft_bits_q, data_addr_q, stop_q, start_q,
                                dir_q, addr_upd_q, full_q};
                end
                `ADDR_CONFIG: begin
                    rdata_o <= {3'h0, cfg_q.ten_bit, cfg_q.polarity, cfg_q.master,
                                cfg_q.i2c, cfg_q.enable};
                end
                `ADDR_IRQ_STATUS: begin
                    rdata_o <= {4'h0, irq_stat_q};
                end
                `ADDR_IRQ_MASK: begin
                    rdata_o <= {4'h0, irq_mask_q};
                end
                `ADDR_DATA: begin
                    rdata_o <= buf_q;
                end
                default: begin
                    rdata_o <= `RESET_BYTE;
                end
            endcase
        end else begin
            // no read this cycle: drive zero
            rdata_o <= `RESET_BYTE;
        end
    end

    // steering outputs, each registered; all but master_idle_o come from the config register and the phase bits
    // the phase bits mean different things in the two protocols, so each
    // phase-bit output is gated by the mode bit and only one meaning is ever live
    // idle is reported high out of reset since nothing is requested yet
    // one cycle of lag after a config write is harmless for pin steering
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            sample_at_end_o <= 1'b0;
            slew_ctrl_on_o <= 1'b0;
            shift_on_rise_o <= 1'b0;
            smbus_levels_o <= 1'b0;
            clk_idle_level_o <= 1'b0;
            pins_to_port_o <= 1'b0;
            i2c_mode_o <= 1'b0;
            master_idle_o <= 1'b1;
        end else begin
            // the slave never sees phase set, so master-only gating is safe
            sample_at_end_o <= !cfg_q.i2c && cfg_q.master && soft_bits_q[1];
            slew_ctrl_on_o <= cfg_q.i2c && !soft_bits_q[1];
            // polarity flips which physical edge the edge bit means
            shift_on_rise_o <= !cfg_q.i2c && (soft_bits_q[0] ^ cfg_q.polarity);
            smbus_levels_o <= cfg_q.i2c && soft_bits_q[0];
            clk_idle_level_o <= !cfg_q.i2c && cfg_q.polarity;
            pins_to_port_o <= cfg_q.enable;
            i2c_mode_o <= cfg_q.i2c;
            master_idle_o <= !(dir_q || (|master_req_i));
        end
    end

endmodule // sync_serial_port_status
`default_nettype wire

// file: testbench/port_status_properties.sv
`timescale 1ns/1ns
`default_nettype none
// watches the register port and a few steering outputs of the status block
module port_status_checker (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic rx_done_i,
    input wire logic rx_is_data_i,
    input wire logic tx_start_i,
    input wire logic [4:0] master_req_i,
    input wire logic master_idle_o,
    input wire logic i2c_mode_o,
    input wire logic pins_to_port_o
);
    // one clock domain, so one default for all properties
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);
    // read data stand one cycle only, zero otherwise
    rdata_idle_a: assert property (!rd_i |=> rdata_o == 8'h00)
        else $error("read data not zero");
    // the two upper bits keep what software wrote
    status_soft_a: assert property (
        wr_i && addr_i == 8'h94 ##1 !wr_i ##1 rd_i && addr_i == 8'h94
        |=> rdata_o[7:6] == $past(wdata_i[7:6], 3))
        else $error("soft bits lost");
    // a received byte shows as full
    full_set_a: assert property (
        rx_done_i ##2 rd_i && addr_i == 8'h94 |=> rdata_o[0])
        else $error("full not set");
    // a data read empties the buffer when nothing new arrives
    full_clear_a: assert property (
        rd_i && addr_i == 8'hAC && !rx_done_i && !tx_start_i
        ##1 !rx_done_i && !tx_start_i ##1 rd_i && addr_i == 8'h94 |=> !rdata_o[0])
        else $error("full not cleared");
    // byte kind follows the last received byte
    kind_flag_a: assert property (
        rx_done_i && i2c_mode_o ##1 !rx_done_i ##1 rd_i && addr_i == 8'h94
        |=> rdata_o[5] == $past(rx_is_data_i, 3))
        else $error("data flag wrong");
    // any pending request means the master is busy
    busy_idle_a: assert property (|master_req_i |=> !master_idle_o)
        else $error("idle while requested");
    // disabling the port drops the start and stop flags
    flags_off_a: assert property (
        wr_i && addr_i == 8'hA0 && !wdata_i[0] ##1 !wr_i ##1 rd_i && addr_i == 8'h94
        |=> rdata_o[4:3] == 2'b00)
        else $error("start stop kept");
    // pin ownership follows the enable bit within three cycles
    pins_cfg_a: assert property (
        wr_i && addr_i == 8'hA0 ##1 !wr_i [*2] |=> pins_to_port_o == $past(wdata_i[0], 3))
        else $error("pins not steered");
endmodule // port_status_checker
`default_nettype wire

// file: testbench/i2c_bus_peer.sv
`timescale 1ns/1ns
`default_nettype none
// far-side controller: drives the link clock and data, idle high (pull-ups)
module i2c_bus_peer (
    output logic scl_o,
    output logic sda_o
);
    // link clock stands high between frames
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    // start: data falls under a high clock, then eight 125 ns clocks
    task automatic start_cond();
        #63 sda_o = 1'b0;
        repeat (8) begin
            #62 scl_o = 1'b0;
            #63 scl_o = 1'b1;
        end
        #62 scl_o = 1'b0;
    endtask
    // stop: clock high first, then data rises
    task automatic stop_cond();
        #62 scl_o = 1'b1;
        #63 sda_o = 1'b1;
    endtask
endmodule // i2c_bus_peer
`default_nettype wire

// file: testbench/sync_serial_port_status_tb.sv
`timescale 1ns/1ns
`default_nettype none
module sync_serial_port_status_tb;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [7:0] addr_i = 8'h00;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [7:0] rdata_o;
    logic irq_o;
    logic scl, sda; // link pins from the peer
    logic [5:0] ev = 6'h00; // rx, tx start, tx done, match, nack, high addr
    logic is_data = 1'b0;
    logic rw = 1'b0;
    logic [7:0] rx_b = 8'h3C;
    logic [4:0] req = 5'h00;
    logic [7:0] outs; // steering outputs, bit order as wired below
    int fail_count = 0;
    int total_checks = 0;
    int cyc = 0;
    always #5 clk_i = ~clk_i;
    i2c_bus_peer PEER (.scl_o(scl), .sda_o(sda));
    sync_serial_port_status DUT (.clk_i, .sys_rst_i, .addr_i, .wdata_i, .wr_i, .rd_i,
        .rdata_o, .irq_o, .scl_i(scl), .sda_i(sda), .rx_done_i(ev[0]),
        .rx_is_data_i(is_data), .rx_byte_i(rx_b), .tx_start_i(ev[1]),
        .tx_bits_done_i(ev[2]), .addr_match_i(ev[3]), .addr_rw_i(rw), .nack_i(ev[4]),
        .addr_high_done_i(ev[5]), .master_req_i(req), .sample_at_end_o(outs[0]),
        .slew_ctrl_on_o(outs[1]), .shift_on_rise_o(outs[2]), .smbus_levels_o(outs[3]),
        .clk_idle_level_o(outs[4]), .pins_to_port_o(outs[5]), .i2c_mode_o(outs[6]),
        .master_idle_o(outs[7]));
    task automatic conclude();
        $display("checks %0d errors %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
        total_checks++;
        if (s !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    // data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 chk($sformatf("reg_%h", a), e, rdata_o);
    endtask
    task automatic pulse(input int i);
        @(posedge clk_i);
        ev[i] <= 1'b1;
        @(posedge clk_i);
        ev[i] <= 1'b0;
    endtask
    // outputs are registered behind the config registers, so let them settle
    task automatic see(input logic [7:0] m, input logic [7:0] e);
        repeat (3) @(posedge clk_i);
        #1 chk("outs", e, outs & m);
    endtask
    // hang guard, far above the few hundred cycles the sequence needs
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            conclude();
        end
    end
    initial begin
        repeat (5) @(posedge clk_i);
        #1 chk("reset_outs", 8'h80, outs);
        @(posedge clk_i);
        sys_rst_i <= 1'b0;
        rd(8'h94, 8'h00);
        rd(8'h00, 8'h00);
        wr(8'h94, 8'hFF);
        rd(8'h94, 8'hC0);
        wr(8'hA0, 8'h03);
        see(8'h6A, 8'h68);
        wr(8'h94, 8'h00);
        see(8'h0A, 8'h02);
        PEER.start_cond();
        rd(8'h94, 8'h08);
        chk("irq", 8'h00, {7'h00, irq_o});
        wr(8'hA8, 8'h02);
        repeat (2) @(posedge clk_i);
        #1 chk("irq", 8'h01, {7'h00, irq_o});
        PEER.stop_cond();
        repeat (8) @(posedge clk_i);
        rd(8'h94, 8'h10);
        wr(8'hA4, 8'h02);
        repeat (2) @(posedge clk_i);
        #1 chk("irq", 8'h00, {7'h00, irq_o});
        rd(8'hA4, 8'h04);
        wr(8'hA0, 8'h02);
        rd(8'h94, 8'h00);
        see(8'h20, 8'h00);
        wr(8'hA0, 8'h07);
        pulse(0);
        rd(8'h94, 8'h01);
        rd(8'hAC, 8'h3C);
        @(posedge clk_i);
        is_data <= 1'b1;
        rx_b <= 8'hA5;
        pulse(0);
        rd(8'h94, 8'h21);
        rd(8'hAC, 8'hA5);
        rd(8'h94, 8'h20);
        pulse(1);
        rd(8'h94, 8'h25);
        chk("idle", 8'h00, {7'h00, outs[7]});
        pulse(2);
        rd(8'h94, 8'h20);
        chk("idle", 8'h01, {7'h00, outs[7]});
        @(posedge clk_i);
        req <= 5'h04;
        repeat (2) @(posedge clk_i);
        #1 chk("idle", 8'h00, {7'h00, outs[7]});
        @(posedge clk_i);
        req <= 5'h00;
        wr(8'hA0, 8'h03);
        @(posedge clk_i);
        rw <= 1'b1;
        pulse(3);
        rd(8'h94, 8'h24);
        pulse(4);
        rd(8'h94, 8'h20);
        wr(8'hA0, 8'h13);
        pulse(5);
        rd(8'h94, 8'h22);
        wr(8'hAC, 8'h00);
        rd(8'h94, 8'h20);
        wr(8'hA0, 8'h0D);
        wr(8'h94, 8'hC0);
        see(8'h75, 8'h31);
        wr(8'h94, 8'h40);
        wr(8'hA0, 8'h05);
        see(8'h15, 8'h04);
        wr(8'h94, 8'h40);
        wr(8'hA0, 8'h01);
        see(8'h75, 8'h24);
        conclude();
    end
endmodule // sync_serial_port_status_tb
bind sync_serial_port_status port_status_checker CHK (.clk_i, .sys_rst_i, .addr_i,
    .wdata_i, .wr_i, .rd_i, .rdata_o, .rx_done_i, .rx_is_data_i, .tx_start_i,
    .master_req_i, .master_idle_o, .i2c_mode_o, .pins_to_port_o);
`default_nettype wire
